// [rtl/fmb_top.sv]
`include "fmb_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module fmb_top #(
    parameter int ADDR_W = 32
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [ADDR_W-1:0]  paddr,
    input  wire logic [31:0]        pwdata,
    input  wire logic [3:0]         pstrb,
    output logic                    pready,
    output logic [31:0]             prdata,
    output logic                    pslverr,
    input  wire logic               protect_pin,
    input  wire logic               mode_pin_a,
    input  wire logic               mode_pin_b,
    output fmb_pkg::fmb_mode_t      op_mode,
    output logic                    flash_ew_mode,
    output logic                    flash_fetch_block,
    output logic [31:0]             reset_vector,
    output logic [31:0]             ei_vector,
    output logic                    flash_entry_bit,
    output logic                    emulation_mode_bit,
    output logic                    deep_erase_select,
    output logic                    flash_abort_bit,
    output logic                    array_status_load,
    output logic [7:0]              array_status_value,
    output fmb_pkg::fmb_bank_t      large_bank,
    output fmb_pkg::fmb_bank_t [1:0] small_bank
);

    ////////////////////////////////////////////////////////////////
    // Elaboration check

    // Index times four must fit the address bus
    initial begin
        if (ADDR_W < 27 || ADDR_W > 32) begin
            $error("fmb_top: ADDR_W must be 27 to 32");
        end
    end

    ////////////////////////////////////////////////////////////////
    // State

    fmb_pkg::fmb_state_t st;       // Registered state
    fmb_pkg::fmb_state_t next_st;  // Next state

    // Reset image of the state
    localparam fmb_pkg::fmb_state_t RST = '{
        sync1:      3'h0,
        sync2:      3'h0,
        armed:      1'b0,
        entry:      1'b0,
        emul:       1'b0,
        depth:      1'b0,
        abort:      1'b0,
        init_pulse: 1'b0,
        status_val: `FMB_ARRAY_STATUS_INIT,
        lb_en:      1'b0,
        lb_base:    7'h00,
        sb_en:      2'h0,
        sb_base:    `FMB_HALF_RESET,
        ack:        1'b0,
        err:        1'b0,
        rdata:      32'h0000_0000
    };

    ////////////////////////////////////////////////////////////////
    // Address helpers

    // Byte address of a register index
    function automatic logic [ADDR_W-1:0] adr(input logic [31:0] idx);
        logic [31:0] a;
        a = {idx[29:0], 2'b00};
        return a[ADDR_W-1:0];
    endfunction

    // Address hits, decoded once
    logic hit_port8;   // Port data
    logic hit_entry;   // Entry control
    logic hit_depth;   // Erase depth
    logic hit_abort;   // Abort control
    logic hit_lbank;   // Large bank
    logic hit_sb0;     // Small bank zero
    logic hit_sb1;     // Small bank one
    logic hit_any;     // Any mapped register

    // Address decode
    always_comb begin
        hit_port8 = (paddr == adr(`FMB_IDX_PORT8));
        hit_entry = (paddr == adr(`FMB_IDX_ENTRY));
        hit_depth = (paddr == adr(`FMB_IDX_DEPTH));
        hit_abort = (paddr == adr(`FMB_IDX_ABORT));
        hit_lbank = (paddr == adr(`FMB_IDX_LBANK));
        hit_sb0   = (paddr == adr(`FMB_IDX_SBANK0));
        hit_sb1   = (paddr == adr(`FMB_IDX_SBANK1));
        hit_any   = hit_port8 | hit_entry | hit_depth | hit_abort
                  | hit_lbank | hit_sb0 | hit_sb1;
    end

    ////////////////////////////////////////////////////////////////
    // Mode decode from synchronised pins

    logic               prot;      // Protect pin, synced
    logic               pin_a;     // Mode pin a, synced
    logic               pin_b;     // Mode pin b, synced
    fmb_pkg::fmb_mode_t mode;      // Decoded operating mode
    logic               may_enter; // Entry to write mode allowed

    // Only the second sync stage is read by the decode
    always_comb begin
        prot  = st.sync2[2];
        pin_a = st.sync2[1];
        pin_b = st.sync2[0];
        if (pin_a && pin_b) begin
            mode = fmb_pkg::FMB_RSVD;
        end else if (pin_a) begin
            // Protect level splits boot from processor
            mode = prot ? fmb_pkg::FMB_BOOT
                        : fmb_pkg::FMB_PROC;
        end else if (pin_b) begin
            mode = fmb_pkg::FMB_EXT;
        end else begin
            mode = fmb_pkg::FMB_SINGLE;
        end
        // Boot counts as single chip with a boot vector
        may_enter = prot && (mode == fmb_pkg::FMB_SINGLE ||
                             mode == fmb_pkg::FMB_EXT ||
                             mode == fmb_pkg::FMB_BOOT);
    end

    ////////////////////////////////////////////////////////////////
    // Next-state logic

    logic        acc;      // First access cycle
    logic        wr;       // Write taken this edge
    logic        wr8;      // Byte lane present
    logic        wr16;     // Both low lanes present
    logic [31:0] rd;       // Read value
    integer      i;        // Small bank loop

    always_comb begin
        next_st = st;
        rd      = 32'h0000_0000;
        // Two-stage pin synchroniser
        next_st.sync1 = {protect_pin, mode_pin_a, mode_pin_b};
        next_st.sync2 = st.sync1;
        next_st.init_pulse = 1'b0;

        // One wait state: data sampled, then ready
        acc  = psel && penable && !st.ack;
        wr   = psel && penable && st.ack && pwrite && !st.err;
        wr8  = pstrb[0];
        wr16 = pstrb[0] && pstrb[1];
        next_st.ack = acc;

        // Read mux; unused bits stay zero
        if (hit_port8) begin
            rd[`FMB_MODE_A_BIT] = pin_a;
            rd[`FMB_MODE_B_BIT] = pin_b;
        end else if (hit_entry) begin
            rd[`FMB_ENTRY_BIT] = st.entry;
            rd[`FMB_EMUL_BIT]  = st.emul;
        end else if (hit_depth) begin
            rd[`FMB_DEPTH_BIT] = st.depth;
        end else if (hit_abort) begin
            rd[`FMB_ABORT_BIT] = st.abort;
        end else if (hit_lbank) begin
            rd[`FMB_BANK_EN_BIT] = st.lb_en;
            rd[`FMB_LBASE_LSB +: 7] = st.lb_base;
        end else if (hit_sb0) begin
            rd[`FMB_BANK_EN_BIT] = st.sb_en[0];
            rd[`FMB_SBASE_LSB +: 8] = st.sb_base[7:0];
        end else if (hit_sb1) begin
            rd[`FMB_BANK_EN_BIT] = st.sb_en[1];
            rd[`FMB_SBASE_LSB +: 8] = st.sb_base[15:8];
        end else begin
            rd = 32'h0000_0000;
        end
        if (acc) begin
            next_st.rdata = pwrite ? 32'h0000_0000 : rd;
            next_st.err   = !hit_any;
        end

        // Entry control register
        if (wr && hit_entry && wr8) begin
            if (!pwdata[`FMB_ENTRY_BIT]) begin
                // A zero clears entry and arms the sequence when protect is high
                next_st.entry = 1'b0;
                next_st.armed = prot;
            end else begin
                if (st.armed && may_enter) begin
                    next_st.entry = 1'b1;
                end
                next_st.armed = 1'b0;
            end
            if (pwdata[`FMB_EMUL_BIT]) begin
                // Emulation only from normal read state
                if (!st.entry) begin
                    next_st.emul = 1'b1;
                end
            end else begin
                next_st.emul = 1'b0;
            end
        end

        // Erase depth register
        if (wr && hit_depth && wr8) begin
            next_st.depth = pwdata[`FMB_DEPTH_BIT];
        end

        // Abort register, live only with entry set
        if (wr && hit_abort && wr8 && st.entry) begin
            next_st.abort = pwdata[`FMB_ABORT_BIT];
            if (pwdata[`FMB_ABORT_BIT]) begin
                next_st.init_pulse = 1'b1;
                next_st.status_val = `FMB_ARRAY_STATUS_INIT;
            end
        end

        // Bank registers need a full halfword
        if (wr && hit_lbank && wr16) begin
            next_st.lb_en = pwdata[`FMB_BANK_EN_BIT] && st.emul;
            next_st.lb_base = pwdata[`FMB_LBASE_LSB +: 7];
        end
        for (i = 0; i < 2; i = i + 1) begin
            if (wr && wr16 && ((i == 0) ? hit_sb0 : hit_sb1)) begin
                next_st.sb_en[i] =
                    pwdata[`FMB_BANK_EN_BIT] && st.emul;
                next_st.sb_base[i*8 +: 8] =
                    pwdata[`FMB_SBASE_LSB +: 8];
            end
        end

        // Protect low drops entry; that covers its fall
        if (!prot) begin
            next_st.entry = 1'b0;
            next_st.armed = 1'b0;
        end
        // Abort has no meaning once entry is gone
        if (!next_st.entry) begin
            next_st.abort = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // State register

    // Asynchronous reset loads constants only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= RST;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Outputs

    logic ew;  // Write mode active

    // Bus answer and mode outputs
    always_comb begin
        pready  = st.ack;
        prdata  = st.rdata;
        pslverr = st.ack && st.err;

        // Entry is only ever set where allowed
        ew = st.entry && prot;
        op_mode = mode;
        flash_ew_mode = ew;
        flash_fetch_block = ew;

        // Boot fetches from the boot area
        reset_vector = (mode == fmb_pkg::FMB_BOOT)
                     ? `FMB_VEC_BOOT
                     : `FMB_VEC_FLASH;
        // Interrupt entry moves to RAM in write mode
        ei_vector = ew ? `FMB_EI_RAM : `FMB_EI_FLASH;

        flash_entry_bit    = st.entry;
        emulation_mode_bit = st.emul;
        deep_erase_select  = st.depth;
        flash_abort_bit    = st.abort;
        array_status_load  = st.init_pulse;
        array_status_value = st.status_val;

        // Bank start addresses: field lands on A12 up
        large_bank.en    = st.lb_en;
        large_bank.start = {13'h0000, st.lb_base,
                            12'h000};
        small_bank[0].en    = st.sb_en[0];
        small_bank[0].start = {12'h000, st.sb_base[7:0],
                               12'h000};
        small_bank[1].en    = st.sb_en[1];
        small_bank[1].start = {12'h000, st.sb_base[15:8],
                               12'h000};
    end

endmodule

`default_nettype wire

// [rtl/fmb_consts.svh]
`ifndef FMB_CONSTS_SVH
`define FMB_CONSTS_SVH

// Register indexes; byte address is four times the index
`define FMB_IDX_PORT8      32'h0080_0708
`define FMB_IDX_ENTRY      32'h0080_07E2
`define FMB_IDX_DEPTH      32'h0080_07E4
`define FMB_IDX_ABORT      32'h0080_07E5
`define FMB_IDX_LBANK      32'h0080_07E8
`define FMB_IDX_SBANK0     32'h0080_07F0
`define FMB_IDX_SBANK1     32'h0080_07F2

// Field positions within the low data bits
`define FMB_DEPTH_BIT      0
`define FMB_ABORT_BIT      0
`define FMB_ENTRY_BIT      4
`define FMB_EMUL_BIT       0
`define FMB_BANK_EN_BIT    15
`define FMB_LBASE_LSB      1
`define FMB_SBASE_LSB      0
`define FMB_MODE_A_BIT     7
`define FMB_MODE_B_BIT     6
`define FMB_BANK_ADR_LSB   12

// Reset and restore values
`define FMB_ARRAY_STATUS_INIT 8'h80
`define FMB_BYTE_RESET        8'h00
`define FMB_HALF_RESET        16'h0000

// Vector locations
`define FMB_VEC_BOOT       32'h8000_0000
`define FMB_VEC_FLASH      32'h0000_0000
`define FMB_EI_FLASH       32'h0000_0080
`define FMB_EI_RAM         32'h0080_4000

`endif

// [rtl/fmb_pkg.sv]
package fmb_pkg;

    // Operating mode chosen by the pins
    typedef enum logic [2:0] {
        FMB_SINGLE = 3'h0,
        FMB_PROC   = 3'h1,
        FMB_EXT    = 3'h2,
        FMB_BOOT   = 3'h3,
        FMB_RSVD   = 3'h4
    } fmb_mode_t;

    // One emulation bank window
    typedef struct packed {
        logic        en;
        logic [31:0] start;
    } fmb_bank_t;

    // Whole state of the block
    typedef struct packed {
        logic [2:0]  sync1;
        logic [2:0]  sync2;
        logic        armed;
        logic        entry;
        logic        emul;
        logic        depth;
        logic        abort;
        logic        init_pulse;
        logic [7:0]  status_val;
        logic        lb_en;
        logic [6:0]  lb_base;
        logic [1:0]  sb_en;
        logic [15:0] sb_base;
        logic        ack;
        logic        err;
        logic [31:0] rdata;
    } fmb_state_t;

endpackage

// [dv/fmb_top_asserts.sv]
`timescale 1ns/10ps
`default_nettype none

module fmb_top_asserts (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               penable,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire fmb_pkg::fmb_mode_t op_mode,
    input wire logic               flash_ew_mode,
    input wire logic               flash_fetch_block,
    input wire logic [31:0]        reset_vector,
    input wire logic [31:0]        ei_vector,
    input wire logic               flash_entry_bit,
    input wire logic               emulation_mode_bit,
    input wire logic               flash_abort_bit,
    input wire logic               array_status_load,
    input wire logic [7:0]         array_status_value,
    input wire fmb_pkg::fmb_bank_t large_bank
);

    ////////////////////////////////////////////////////////////////////////
    // One domain, so clock and reset are stated once
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Exactly one wait state on every access
    a_ready_wait: assert property ($rose(penable) |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_fetch_block: assert property (flash_fetch_block == flash_ew_mode)
        else $error("flash fetch block differs from write mode");
    a_ew_entry: assert property (flash_ew_mode |-> flash_entry_bit)
        else $error("write mode without entry bit");
    // Stable inputs avoid blaming a one-cycle decode lag
    a_ei_vector: assert property ($stable(flash_ew_mode) |->
        ei_vector == (flash_ew_mode ? 32'h0080_4000 : 32'h0000_0080))
        else $error("ei vector wrong");
    a_reset_vec: assert property ($stable(op_mode) |->
        reset_vector == ((op_mode == fmb_pkg::FMB_BOOT) ? 32'h8000_0000
                                                        : 32'h0000_0000))
        else $error("reset vector wrong");
    a_lb_align: assert property (large_bank.start[11:0] == 12'h000 &&
        large_bank.start[31:19] == 13'h0000)
        else $error("large bank start outside A12-A18");
    a_abort_entry: assert property (flash_abort_bit && !flash_entry_bit
        |=> !flash_abort_bit)
        else $error("abort bit kept without entry");
    a_status_load: assert property (array_status_load |=>
        !array_status_load && array_status_value == 8'h80)
        else $error("status restore pulse wrong");
    a_load_cause: assert property (array_status_load |->
        flash_abort_bit && flash_entry_bit)
        else $error("status restore without accepted abort");
    a_emul_set: assert property ($rose(emulation_mode_bit) |->
        !$past(flash_entry_bit))
        else $error("emulation set while entry set");
    a_lb_enable: assert property ($rose(large_bank.en) |->
        $past(emulation_mode_bit))
        else $error("large bank enabled outside emulation");

endmodule

`default_nettype wire

// [dv/fmb_pin_model.sv]
`timescale 1ns/10ps
`default_nettype none

module fmb_pin_model (
    input  wire logic       pclk,
    input  wire logic [2:0] pin_req,
    output logic            protect_pin,
    output logic            mode_pin_a,
    output logic            mode_pin_b
);

    ////////////////////////////////////////////////////////////////////////
    // Straps start low; real boards give no clean level before reset ends
    initial {protect_pin, mode_pin_a, mode_pin_b} = 3'b000;

    // Straps move just after an edge, like a jumper flipped on the board;
    // dropping protect is how the board takes entry away
    always @(posedge pclk) begin
        {protect_pin, mode_pin_a, mode_pin_b} <= pin_req;
    end

endmodule

`default_nettype wire

// [dv/fmb_top_tb.sv]
`include "fmb_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module fmb_top_tb;

    ////////////////////////////////////////////////////////////////////////
    logic                     pclk, presetn, psel, penable, pwrite;
    logic [31:0]              paddr, pwdata, prdata, reset_vector, ei_vector;
    logic [3:0]               pstrb;
    logic                     pready, pslverr, flash_ew_mode, flash_fetch_block;
    logic                     flash_entry_bit, emulation_mode_bit;
    logic                     deep_erase_select, flash_abort_bit;
    logic                     array_status_load, protect_pin;
    logic                     mode_pin_a, mode_pin_b;
    logic [7:0]               array_status_value;
    logic [2:0]               pin_req;    // Strap setting for the pin model
    fmb_pkg::fmb_mode_t       op_mode;
    fmb_pkg::fmb_bank_t       large_bank;
    fmb_pkg::fmb_bank_t [1:0] small_bank;
    int                       num_errors, check_count, cyc;
    logic [32:0]              exp_q[$];   // Expected {pslverr, prdata}
    logic [31:0]              seed = 32'h0968214D;
    logic [31:0]              r;
    // Strap table: pins, expected mode, expected port bits
    logic [2:0]               pin_v [5] = '{3'h4, 3'h6, 3'h5, 3'h2, 3'h7};
    logic [7:0]               prt_v [5] = '{8'h00, 8'h80, 8'h40, 8'h80, 8'hC0};
    logic [2:0]               md_v  [5] = '{3'h0, 3'h3, 3'h2, 3'h1, 3'h4};

    fmb_top i_fmb_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .protect_pin(protect_pin), .mode_pin_a(mode_pin_a),
        .mode_pin_b(mode_pin_b), .op_mode(op_mode),
        .flash_ew_mode(flash_ew_mode), .flash_fetch_block(flash_fetch_block),
        .reset_vector(reset_vector), .ei_vector(ei_vector),
        .flash_entry_bit(flash_entry_bit),
        .emulation_mode_bit(emulation_mode_bit),
        .deep_erase_select(deep_erase_select),
        .flash_abort_bit(flash_abort_bit),
        .array_status_load(array_status_load),
        .array_status_value(array_status_value), .large_bank(large_bank),
        .small_bank(small_bank));

    fmb_pin_model i_fmb_pin_model (.pclk(pclk), .pin_req(pin_req),
        .protect_pin(protect_pin), .mode_pin_a(mode_pin_a),
        .mode_pin_b(mode_pin_b));

    ////////////////////////////////////////////////////////////////////////
    // Free-running 20 MHz clock
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // Fixed-seed xorshift keeps every run identical
    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task close_out;
        if (num_errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(string nm, logic [32:0] seen, logic [32:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer; waits on pready, no assumed latency
    task automatic apb(logic wr, logic [31:0] idx, logic [31:0] wd,
                       logic [3:0] st, logic [32:0] exp);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= idx << 2;
        pwdata  <= wd;
        pstrb   <= st;
        if (!wr) exp_q.push_back(exp);
        @(posedge pclk);
        penable <= 1'b1;
        // Look at pready mid-cycle, where it has settled
        do @(negedge pclk); while (pready !== 1'b1);
        @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
        // Let the write land before any caller looks at outputs
        @(negedge pclk);
    endtask

    // Strap changes pass a two-flop sync, so give them room
    task automatic pins(logic [2:0] v);
        pin_req <= v;
        repeat (6) @(posedge pclk);
        @(negedge pclk);
    endtask

    // Read monitor takes the oldest note at each completed read;
    // sampled mid-cycle so the registered answer has settled
    always @(negedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (exp_q.size() == 0) check("read queue", 33'h0, 33'h1);
            else check("prdata", {pslverr, prdata}, exp_q.pop_front());
        end
    end

    // Hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            close_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        pin_req = 3'h4;
        presetn = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `FMB_IDX_DEPTH, 0, 4'hF, 33'h0);
        apb(0, `FMB_IDX_ABORT, 0, 4'hF, 33'h0);
        apb(0, `FMB_IDX_LBANK, 0, 4'h3, 33'h0);
        apb(0, `FMB_IDX_SBANK0, 0, 4'h3, 33'h0);
        apb(0, `FMB_IDX_SBANK1, 0, 4'h3, 33'h0);
        check("status", array_status_value, 8'h80);
        for (int i = 0; i < 5; i++) begin
            pins(pin_v[i]);
            check("mode", op_mode, md_v[i]);
            check("rvec", reset_vector, i == 1 ? 32'h8000_0000 : 0);
            apb(0, `FMB_IDX_PORT8, 0, 4'hF, {25'h0, prt_v[i]});
        end
        pins(3'h4);
        apb(1, `FMB_IDX_ABORT, 1, 4'hF, 0);
        check("abort", flash_abort_bit, 0);
        r = xs();
        apb(1, `FMB_IDX_ENTRY, 1, 4'hF, 0);
        check("emul", emulation_mode_bit, 1);
        apb(1, `FMB_IDX_LBANK, {r[6:0], 1'b0} | 32'h8000, 4'h3, 0);
        apb(1, `FMB_IDX_LBANK, 0, 4'h1, 0);
        apb(0, `FMB_IDX_LBANK, 0, 4'h3, {r[6:0], 1'b0} | 33'h8000);
        check("lbank", large_bank, {1'b1, 13'h0, r[6:0], 12'h0});
        for (int k = 0; k < 2; k++) begin
            apb(1, `FMB_IDX_SBANK0 + 2 * k, r[8*k+8 +: 8] | 32'h8000, 4'h3, 0);
            apb(0, `FMB_IDX_SBANK0 + 2 * k, 0, 4'h3,
                r[8*k+8 +: 8] | 33'h8000);
            check("sbank", small_bank[k],
                {1'b1, 12'h0, r[8*k+8 +: 8], 12'h0});
        end
        apb(1, `FMB_IDX_ENTRY, 0, 4'hF, 0);
        pins(3'h5);
        apb(1, `FMB_IDX_ENTRY, 32'h00, 4'hF, 0);
        apb(1, `FMB_IDX_ENTRY, 32'h10, 4'hF, 0);
        repeat (2) @(negedge pclk);
        check("ew", {flash_entry_bit, flash_ew_mode}, 2'b11);
        check("ei", ei_vector, 32'h0080_4000);
        check("fetch", flash_fetch_block, 1);
        apb(1, `FMB_IDX_ENTRY, 32'h11, 4'hF, 0);
        check("emul", emulation_mode_bit, 0);
        apb(1, `FMB_IDX_DEPTH, r | 32'h1, 4'hF, 0);
        check("deep", deep_erase_select, 1);
        apb(0, `FMB_IDX_DEPTH, 0, 4'hF, 33'h1);
        apb(1, `FMB_IDX_ABORT, 1, 4'hF, 0);
        check("abort", flash_abort_bit, 1);
        apb(0, `FMB_IDX_ABORT, 0, 4'hF, 33'h1);
        apb(1, `FMB_IDX_ABORT, 0, 4'hF, 0);
        pins(3'h1);
        check("drop", {flash_entry_bit, flash_ew_mode}, 2'b00);
        check("ei", ei_vector, 32'h0000_0080);
        pins(3'h2);
        apb(1, `FMB_IDX_ENTRY, 32'h00, 4'hF, 0);
        apb(1, `FMB_IDX_ENTRY, 32'h10, 4'hF, 0);
        repeat (2) @(negedge pclk);
        check("proc", flash_entry_bit, 0);
        apb(0, 32'h0080_0700, 0, 4'hF, {1'b1, 32'h0});
        repeat (2) @(posedge pclk);
        close_out;
    end

endmodule

bind fmb_top fmb_top_asserts i_fmb_top_asserts (.pclk(pclk),
    .presetn(presetn), .penable(penable), .pready(pready),
    .pslverr(pslverr), .op_mode(op_mode), .flash_ew_mode(flash_ew_mode),
    .flash_fetch_block(flash_fetch_block), .reset_vector(reset_vector),
    .ei_vector(ei_vector), .flash_entry_bit(flash_entry_bit),
    .emulation_mode_bit(emulation_mode_bit),
    .flash_abort_bit(flash_abort_bit),
    .array_status_load(array_status_load),
    .array_status_value(array_status_value), .large_bank(large_bank));

`default_nettype wire
